// ---- cslk_params.svh ----
// named constants of the chained sensor alert link, both ends
// assumes inclusion by the package and by both end modules
`ifndef CSLK_PARAMS_SVH
`define CSLK_PARAMS_SVH
`define CSLK_CLK_HZ 100_000_000
`define CSLK_TIMEOUT_MS 28
`define CSLK_IDLE_MS 28
`define CSLK_CNT_W 16
`define CSLK_IDLE_W 23
`define CSLK_CAL_BYTE 8'h55
`define CSLK_CMD_SWRST 8'hB4
`define CSLK_CMD_INIT 8'h8C
`define CSLK_CMD_CLRINT 8'hA9
`define CSLK_ASSIGN_NIB 4'h9
`define CSLK_GRW_TOP 5'h1E
`define CSLK_PTR_TEMP 2'h0
`define CSLK_PTR_CFG 2'h1
`define CSLK_PTR_TLOW 2'h2
`define CSLK_PTR_THIGH 2'h3
`define CSLK_CFG_RST 16'h0200
`define CSLK_TLOW_RST 16'h3C00
`define CSLK_THIGH_RST 16'hF600
`define CSLK_CFG_WMASK 16'h9FFF
`define CSLK_BIT_INT_EN 11
`define CSLK_BIT_LC 12
`define CSLK_BIT_FL 13
`define CSLK_BIT_FH 14
`define CSLK_PH_CAL 2'h0
`define CSLK_PH_CMD 2'h1
`define CSLK_PH_DATA 2'h2
`define CSLK_PH_GRD 2'h3
`define CSLK_LAST_DBIT 4'h7
`define CSLK_LAST_FBIT 4'h9
`define CSLK_HREG_TX 2'h0
`define CSLK_HREG_BAUD 2'h1
`define CSLK_HREG_STAT 2'h2
`define CSLK_HREG_RX 2'h3
`define CSLK_STAT_TXBUSY 0
`define CSLK_STAT_RXVAL 1
`define CSLK_STAT_RXLVL 2
`define CSLK_BAUD_DEF 16'h0364
`endif

// ---- cslk_pkg.sv ----
// types shared by the two ends of the chained sensor alert link
// assumes cslk_params.svh on the include path
`include "cslk_params.svh"
package cslk_pkg;
  typedef enum logic [2:0] {
    st_cal = 3'b000,
    st_meas = 3'b001,
    st_wait = 3'b010,
    st_bits = 3'b011,
    st_stop = 3'b100
  } cslk_rx_st_t;

  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic rx_d;
    cslk_rx_st_t st;
    logic [1:0] phase;
    logic [`CSLK_CNT_W-1:0] bit_per;
    logic [`CSLK_CNT_W-1:0] cnt;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic [7:0] wlo;
    logic [4:0] ndata;
    logic [`CSLK_IDLE_W-1:0] idle;
    logic [15:0] cfg;
    logic [15:0] tlow;
    logic [15:0] thigh;
    logic [3:0] id;
    logic addr_mode;
    logic alert;
    logic tx_on;
    logic [9:0] tx_sh;
    logic [3:0] tx_bit;
    logic [`CSLK_CNT_W-1:0] tx_cnt;
    logic [7:0] tx_q;
    logic tx_q_v;
    logic tx_line;
  } cslk_dev_st_t;

  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic rx_d;
    logic ron;
    logic [`CSLK_CNT_W-1:0] rcnt;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic [7:0] rdata;
    logic rval;
    logic ton;
    logic [9:0] tsh;
    logic [3:0] tbit;
    logic [`CSLK_CNT_W-1:0] tcnt;
    logic line;
    logic [`CSLK_CNT_W-1:0] baud;
    logic [15:0] rd;
  } cslk_host_st_t;
endpackage

// ---- cslk_link_if.sv ----
// the two wires between host and sensor, push-pull both ways
// assumes a testbench chains several sensors by joining instances
`timescale 1ns/1ps
`default_nettype none
interface cslk_link_if;
  logic host_to_dev;
  logic dev_to_host;
  modport dev (input host_to_dev, output dev_to_host);
  modport host (output host_to_dev, input dev_to_host);
endinterface
`default_nettype wire

// ---- cslk_sensor_end.sv ----
// sensor end: limit flags, alert hold-low, byte framing with baud lock, command decode
// assumes conversion results arrive as a one-cycle strobe on i_ref_clk
//
// Overview of operation
// - set high flag when result above high limit
// - set low flag when result below low limit
// - latched flags clear on configuration register read
// - transparent flags clear after in-limit conversion
// - alert needs enable, flag and long idle
// - alert breaks pass-through, drives line low, latched
// - writing enable one also sets latch select
// - clear, soft reset, power-on end alert, enable
// - no alert again until enable rewritten
// - host checks line after calibration byte
// - forward input unless sending, assigning or alerting
// - stall timeout returns link to calibration wait
// - frames: start low, eight bits lsb first, stop
// - calibration byte 55h sets bit timing
// - host sends command then write data bytes
// - addressed read breaks chain, sends register
// - command fields: global, ident, pointer, direction
// - soft reset restores registers except identifier
// - broken chain: only upstream units see reset
// - host repeats soft reset until echoed
// - init command breaks chain for addressing
// - clear command ends alert, forwards, reconnects
// - global access top bits 11110, pointer, direction
`timescale 1ns/1ps
`default_nettype none
`include "cslk_params.svh"
module cslk_sensor_end #(
  parameter int TIMEOUT_CYC = `CSLK_TIMEOUT_MS * (`CSLK_CLK_HZ / 1000),
  parameter int IDLE_CYC = `CSLK_IDLE_MS * (`CSLK_CLK_HZ / 1000)
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  cslk_link_if.dev link,
  input wire logic i_conv_valid,
  input wire logic [15:0] i_conv_temp,
  output logic o_high_limit_flag,
  output logic o_low_limit_flag,
  output logic o_flag_latch_select,
  output logic o_int_en,
  output logic o_alert,
  output logic [3:0] o_unit_id
);
  import cslk_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  cslk_dev_st_t r;
  cslk_dev_st_t nx;
  logic edge_seen;
  logic fall;
  logic done;
  logic [7:0] rb;
  logic hit;
  logic is_glb_rw;
  logic [15:0] wd;
  logic above;
  logic below;

  // load a two-byte transmission, first byte goes out first
  function automatic cslk_dev_st_t start_tx(input cslk_dev_st_t s, input logic [7:0] b0, input logic [7:0] b1);
    cslk_dev_st_t t;
    t = s;
    t.tx_on = 1'b1;
    // one idle-high bit first: keeps the echoed stop bit whole and gives a rising edge after an alert
    t.tx_sh = {b0, 1'b0, 1'b1};
    t.tx_bit = '1;
    t.tx_cnt = s.bit_per - 1'b1;
    t.tx_q = b1;
    t.tx_q_v = 1'b1;
    return t;
  endfunction

  function automatic logic [15:0] reg_sel(input cslk_dev_st_t s, input logic [1:0] p, input logic [15:0] t);
    logic [15:0] v;
    v = t;
    case (p)
      `CSLK_PTR_CFG: v = s.cfg;
      `CSLK_PTR_TLOW: v = s.tlow;
      `CSLK_PTR_THIGH: v = s.thigh;
      default: v = t;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nx = r;
    nx.rx_s1 = link.host_to_dev;
    nx.rx_s2 = r.rx_s1;
    nx.rx_d = r.rx_s2;
    edge_seen = r.rx_s2 != r.rx_d;
    fall = r.rx_d & ~r.rx_s2;
    done = 1'b0;
    rb = r.shreg;
    hit = 1'b0;
    is_glb_rw = 1'b0;
    wd = {r.shreg, r.wlo};
    above = 1'b0;
    below = 1'b0;
    if (edge_seen) begin
      nx.idle = '0;
    end else if (r.idle != '1) begin
      nx.idle = r.idle + 1'b1;
    end
    // receiver; the start bit of the calibration byte is one bit long
    case (r.st)
      st_cal: begin
        if (fall) begin
          nx.st = st_meas;
          nx.cnt = '0;
          nx.phase = `CSLK_PH_CAL;
        end
      end
      st_meas: begin
        nx.cnt = r.cnt + 1'b1;
        if (r.rx_s2) begin
          nx.bit_per = r.cnt + 1'b1;
          nx.cnt = r.cnt >> 1;
          nx.bitn = '0;
          nx.st = st_bits;
        end
      end
      st_wait: begin
        if (fall) begin
          nx.cnt = r.bit_per + (r.bit_per >> 1) - 1'b1;
          nx.bitn = '0;
          nx.st = st_bits;
        end
      end
      st_bits: begin
        if (r.cnt == '0) begin
          nx.shreg = {r.rx_s2, r.shreg[7:1]};
          nx.cnt = r.bit_per - 1'b1;
          nx.bitn = r.bitn + 1'b1;
          if (r.bitn == `CSLK_LAST_DBIT) begin
            nx.st = st_stop;
          end
        end else begin
          nx.cnt = r.cnt - 1'b1;
        end
      end
      st_stop: begin
        if (r.cnt == '0) begin
          done = r.rx_s2;
          nx.st = st_cal;
        end else begin
          nx.cnt = r.cnt - 1'b1;
        end
      end
      default: nx.st = st_cal;
    endcase
    // stall guard: a frame in progress cannot sit this long without an edge
    if (r.st != st_cal && r.idle > (`CSLK_IDLE_W)'(TIMEOUT_CYC)) begin
      nx.st = st_cal;
      nx.phase = `CSLK_PH_CAL;
    end
    ////////////////////////////////////////////////////////////////////////////
    // transmitter
    if (r.tx_on) begin
      if (r.tx_cnt == '0) begin
        nx.tx_cnt = r.bit_per - 1'b1;
        nx.tx_sh = {1'b1, r.tx_sh[9:1]};
        nx.tx_bit = r.tx_bit + 1'b1;
        if (r.tx_bit == `CSLK_LAST_FBIT) begin
          if (r.tx_q_v) begin
            nx.tx_sh = {1'b1, r.tx_q, 1'b0};
            nx.tx_bit = '0;
            nx.tx_q_v = 1'b0;
          end else begin
            nx.tx_on = 1'b0;
          end
        end
      end else begin
        nx.tx_cnt = r.tx_cnt - 1'b1;
      end
    end
    ////////////////////////////////////////////////////////////////////////////
    // byte handling by phase
    if (done) begin
      case (r.phase)
        `CSLK_PH_CAL: begin
          if (rb == `CSLK_CAL_BYTE) begin
            nx.phase = `CSLK_PH_CMD;
            nx.st = st_wait;
          end
        end
        `CSLK_PH_CMD: begin
          nx.cmd = rb;
          is_glb_rw = rb[7:3] == `CSLK_GRW_TOP;
          hit = is_glb_rw || (!rb[7] && rb[6:3] == r.id);
          nx.phase = `CSLK_PH_CAL;
          if (rb == `CSLK_CMD_SWRST) begin
            nx.cfg = `CSLK_CFG_RST;
            nx.tlow = `CSLK_TLOW_RST;
            nx.thigh = `CSLK_THIGH_RST;
            nx.alert = 1'b0;
            nx.addr_mode = 1'b0;
          end else if (rb == `CSLK_CMD_INIT) begin
            nx.addr_mode = 1'b1;
          end else if (r.addr_mode && rb[7:4] == `CSLK_ASSIGN_NIB) begin
            nx.id = rb[3:0];
            nx.addr_mode = 1'b0;
            nx = start_tx(nx, `CSLK_CAL_BYTE, {`CSLK_ASSIGN_NIB, rb[3:0] + 1'b1});
          end else if (rb == `CSLK_CMD_CLRINT) begin
            nx.cfg[`CSLK_BIT_INT_EN] = 1'b0;
            if (r.alert) begin
              nx.alert = 1'b0;
              nx = start_tx(nx, `CSLK_CAL_BYTE, `CSLK_CMD_CLRINT);
            end
          end else if (hit && rb[0]) begin
            if (rb[2:1] == `CSLK_PTR_CFG && r.cfg[`CSLK_BIT_LC]) begin
              nx.cfg[`CSLK_BIT_FH] = 1'b0;
              nx.cfg[`CSLK_BIT_FL] = 1'b0;
            end
            if (is_glb_rw && r.id != '0) begin
              nx.phase = `CSLK_PH_GRD;
              nx.ndata = '0;
              nx.st = st_wait;
            end else begin
              wd = reg_sel(r, rb[2:1], i_conv_temp);
              nx = start_tx(nx, wd[7:0], wd[15:8]);
            end
          end else if (hit) begin
            nx.phase = `CSLK_PH_DATA;
            nx.ndata = '0;
            nx.st = st_wait;
          end
        end
        `CSLK_PH_DATA: begin
          if (r.ndata == '0) begin
            nx.wlo = rb;
            nx.ndata = 5'h01;
            nx.st = st_wait;
          end else begin
            nx.phase = `CSLK_PH_CAL;
            case (r.cmd[2:1])
              `CSLK_PTR_CFG: begin
                nx.cfg = (wd & `CSLK_CFG_WMASK) | (r.cfg & ~`CSLK_CFG_WMASK);
                if (wd[`CSLK_BIT_INT_EN]) begin
                  nx.cfg[`CSLK_BIT_LC] = 1'b1;
                end
              end
              `CSLK_PTR_TLOW: nx.tlow = wd;
              `CSLK_PTR_THIGH: nx.thigh = wd;
              default: nx.cfg = r.cfg;
            endcase
          end
        end
        default: begin
          // upstream units answer a global read first, two bytes each
          nx.ndata = r.ndata + 1'b1;
          nx.st = st_wait;
          if (r.ndata + 1'b1 == {r.id, 1'b0}) begin
            nx.phase = `CSLK_PH_CAL;
            nx.st = st_cal;
            wd = reg_sel(r, r.cmd[2:1], i_conv_temp);
            nx = start_tx(nx, wd[7:0], wd[15:8]);
          end
        end
      endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // limit compare runs last so a fresh flag beats a read clear
    if (i_conv_valid) begin
      above = $signed(i_conv_temp) > $signed(nx.thigh);
      below = $signed(i_conv_temp) < $signed(nx.tlow);
      if (!nx.cfg[`CSLK_BIT_LC] && !above && !below) begin
        nx.cfg[`CSLK_BIT_FH] = 1'b0;
        nx.cfg[`CSLK_BIT_FL] = 1'b0;
      end
      if (above) begin
        nx.cfg[`CSLK_BIT_FH] = 1'b1;
      end
      if (below) begin
        nx.cfg[`CSLK_BIT_FL] = 1'b1;
      end
    end
    if (r.cfg[`CSLK_BIT_INT_EN] && (r.cfg[`CSLK_BIT_FH] || r.cfg[`CSLK_BIT_FL]) && r.rx_s2 &&
        r.idle > (`CSLK_IDLE_W)'(IDLE_CYC) && r.st == st_cal && !r.tx_on && !r.addr_mode) begin
      nx.alert = 1'b1;
    end
    // a unit holding the line low hides later commands from those below
    if (nx.alert) begin
      nx.tx_line = 1'b0;
    end else if (nx.tx_on) begin
      nx.tx_line = nx.tx_sh[0];
    end else if (nx.addr_mode) begin
      nx.tx_line = 1'b1;
    end else begin
      nx.tx_line = r.rx_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
      r.rx_s1 <= 1'b1;
      r.rx_s2 <= 1'b1;
      r.rx_d <= 1'b1;
      r.tx_line <= 1'b1;
      r.cfg <= `CSLK_CFG_RST;
      r.tlow <= `CSLK_TLOW_RST;
      r.thigh <= `CSLK_THIGH_RST;
    end else begin
      r <= nx;
    end
  end

  assign link.dev_to_host = r.tx_line;
  assign o_high_limit_flag = r.cfg[`CSLK_BIT_FH];
  assign o_low_limit_flag = r.cfg[`CSLK_BIT_FL];
  assign o_flag_latch_select = r.cfg[`CSLK_BIT_LC];
  assign o_int_en = r.cfg[`CSLK_BIT_INT_EN];
  assign o_alert = r.alert;
  assign o_unit_id = r.id;
endmodule
`default_nettype wire

// ---- cslk_host_end.sv ----
// host end: byte-wide serial controller driven by software through a small register port
// assumes software sequences calibration, commands and data bytes itself
`timescale 1ns/1ps
`default_nettype none
`include "cslk_params.svh"
module cslk_host_end #(
  parameter logic [`CSLK_CNT_W-1:0] BAUD_DIV = `CSLK_BAUD_DEF
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  cslk_link_if.host link,
  input wire logic [1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata
);
  import cslk_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  cslk_host_st_t r;
  cslk_host_st_t nx;

  always_comb begin
    nx = r;
    nx.rx_s1 = link.dev_to_host;
    nx.rx_s2 = r.rx_s1;
    nx.rx_d = r.rx_s2;
    nx.rd = '0;
    // receiver, also used to catch the echo of a repeated soft reset
    if (!r.ron) begin
      if (r.rx_d && !r.rx_s2) begin
        nx.ron = 1'b1;
        nx.rcnt = r.baud + (r.baud >> 1) - 1'b1;
        nx.rbit = '0;
      end
    end else if (r.rcnt == '0) begin
      nx.rcnt = r.baud - 1'b1;
      if (r.rbit < 4'h8) begin
        nx.rsh = {r.rx_s2, r.rsh[7:1]};
        nx.rbit = r.rbit + 1'b1;
      end else begin
        nx.ron = 1'b0;
      end
    end else begin
      nx.rcnt = r.rcnt - 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    if (r.ton) begin
      if (r.tcnt == '0) begin
        nx.tcnt = r.baud - 1'b1;
        nx.tsh = {1'b1, r.tsh[9:1]};
        nx.tbit = r.tbit + 1'b1;
        if (r.tbit == `CSLK_LAST_FBIT) begin
          nx.ton = 1'b0;
        end
      end else begin
        nx.tcnt = r.tcnt - 1'b1;
      end
    end
    if (i_rd) begin
      case (i_addr)
        `CSLK_HREG_BAUD: nx.rd = r.baud;
        `CSLK_HREG_STAT: begin
          nx.rd[`CSLK_STAT_TXBUSY] = r.ton;
          nx.rd[`CSLK_STAT_RXVAL] = r.rval;
          nx.rd[`CSLK_STAT_RXLVL] = r.rx_s2;
        end
        `CSLK_HREG_RX: begin
          nx.rd = {8'h00, r.rdata};
          nx.rval = 1'b0;
        end
        default: nx.rd = '0;
      endcase
    end
    if (i_wr) begin
      case (i_addr)
        `CSLK_HREG_TX: begin
          if (!r.ton) begin
            nx.ton = 1'b1;
            nx.tsh = {1'b1, i_wdata[7:0], 1'b0};
            nx.tbit = '0;
            nx.tcnt = r.baud - 1'b1;
          end
        end
        `CSLK_HREG_BAUD: nx.baud = i_wdata;
        default: nx.baud = r.baud;
      endcase
    end
    // stop bit check; a new byte wins over a clearing read
    if (r.ron && r.rcnt == '0 && r.rbit == 4'h8 && r.rx_s2) begin
      nx.rdata = r.rsh;
      nx.rval = 1'b1;
    end
    nx.line = nx.ton ? nx.tsh[0] : 1'b1;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
      r.rx_s1 <= 1'b1;
      r.rx_s2 <= 1'b1;
      r.rx_d <= 1'b1;
      r.line <= 1'b1;
      r.baud <= BAUD_DIV;
    end else begin
      r <= nx;
    end
  end

  assign link.host_to_dev = r.line;
  assign o_rdata = r.rd;
endmodule
`default_nettype wire

// ---- cslk_link_chk.sv ----
// checker: link wires and the sensor's flag and alert outputs
// assumes instantiation in the testbench beside the link, one clock domain
`timescale 1ns/1ps
`default_nettype none
module cslk_link_chk #(
  parameter int IDLE_CYC = 2800000
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic host_to_dev,
  input wire logic dev_to_host,
  input wire logic i_conv_valid,
  input wire logic o_high_limit_flag,
  input wire logic o_low_limit_flag,
  input wire logic o_flag_latch_select,
  input wire logic o_int_en,
  input wire logic o_alert
);
  int quiet_cnt;
  logic line_q;

  // saturates so a long idle never wraps back under the alert limit
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      quiet_cnt <= 0;
      line_q <= 1'b1;
    end else begin
      line_q <= host_to_dev;
      if (!host_to_dev || host_to_dev != line_q) quiet_cnt <= 0;
      else if (quiet_cnt < IDLE_CYC + 10) quiet_cnt <= quiet_cnt + 1;
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_alert_cause;
    $rose(o_alert) |-> $past(o_int_en) && ($past(o_high_limit_flag) || $past(o_low_limit_flag));
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert without enable and flag");
  property p_alert_idle;
    $rose(o_alert) |-> quiet_cnt >= IDLE_CYC;
  endproperty
  a_alert_idle: assert property (p_alert_idle) else $error("alert before idle time");
  property p_alert_low;
    o_alert [*2] |-> !dev_to_host;
  endproperty
  a_alert_low: assert property (p_alert_low) else $error("alert not driving line low");
  property p_alert_end;
    $fell(o_alert) |-> ##[0:2] !o_int_en;
  endproperty
  a_alert_end: assert property (p_alert_end) else $error("alert ended with enable kept");
  property p_en_latch;
    $rose(o_int_en) |-> o_flag_latch_select;
  endproperty
  a_en_latch: assert property (p_en_latch) else $error("enable without latch select");
  property p_fh_cause;
    $rose(o_high_limit_flag) |-> $past(i_conv_valid) || $past(i_conv_valid, 2);
  endproperty
  a_fh_cause: assert property (p_fh_cause) else $error("high flag set without conversion");
  property p_fl_cause;
    $rose(o_low_limit_flag) |-> $past(i_conv_valid) || $past(i_conv_valid, 2);
  endproperty
  a_fl_cause: assert property (p_fl_cause) else $error("low flag set without conversion");
  property p_latch_hold;
    o_flag_latch_select && o_high_limit_flag && i_conv_valid |=> o_high_limit_flag [*2];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched flag cleared by conversion");
  // latency up to five cycles is accepted, the level must match afterwards
  property p_pass;
    $past(host_to_dev, 6) != $past(host_to_dev, 5) && $past(host_to_dev, 5) == $past(host_to_dev, 1)
      && !o_alert |-> dev_to_host == $past(host_to_dev, 1);
  endproperty
  a_pass: assert property (p_pass) else $error("line not passed through");
endmodule
`default_nettype wire

// ---- test_chain_sensor_alert_link.sv ----
// testbench: host end and sensor end joined by the link, software steps via the host port
// assumes the design files and cslk_link_chk.sv are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "cslk_params.svh"
module test_chain_sensor_alert_link;
  import cslk_pkg::*;
  localparam int BAUD = 16;
  localparam int SLOW = 3000;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_conv_valid = 1'b0;
  logic [15:0] i_conv_temp = 16'h0000;
  logic [15:0] o_rdata;
  logic fh, fl, lc, ien, alrt;
  logic [3:0] uid;
  logic [15:0] flags;
  logic [15:0] rv;
  int fails = 0;
  int comparisons = 0;
  logic [15:0] rst_tab [4] = '{16'h0000, `CSLK_CFG_RST, `CSLK_TLOW_RST, `CSLK_THIGH_RST};
  logic [15:0] ct [6] = '{16'h0801, 16'h0800, 16'hFFFF, 16'h0400, 16'h00FF, 16'h0100};
  logic [1:0] cf [6] = '{2'b10, 2'b00, 2'b01, 2'b00, 2'b01, 2'b00};
  cslk_link_if link();
  assign flags = {10'h000, link.dev_to_host, alrt, ien, lc, fh, fl};

  cslk_host_end i_cslk_host_end (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .link(link.host),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  cslk_sensor_end #(.TIMEOUT_CYC(SLOW), .IDLE_CYC(SLOW)) i_cslk_sensor_end (.i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn), .link(link.dev), .i_conv_valid(i_conv_valid), .i_conv_temp(i_conv_temp),
    .o_high_limit_flag(fh), .o_low_limit_flag(fl), .o_flag_latch_select(lc), .o_int_en(ien),
    .o_alert(alrt), .o_unit_id(uid));
  cslk_link_chk #(.IDLE_CYC(SLOW)) i_cslk_link_chk (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .host_to_dev(link.host_to_dev), .dev_to_host(link.dev_to_host), .i_conv_valid(i_conv_valid),
    .o_high_limit_flag(fh), .o_low_limit_flag(fl), .o_flag_latch_select(lc), .o_int_en(ien),
    .o_alert(alrt));

  always #5 i_ref_clk = ~i_ref_clk;

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic wait_tx();
    logic [15:0] s;
    s = 16'h0001;
    for (int n = 0; n < 400 && s[0] !== 1'b0; n++) rd(2'h2, s);
    chk(s & 16'h0001, 16'h0000);
  endtask
  task automatic getb(output logic [15:0] d);
    d = 16'h0000;
    for (int n = 0; n < 200 && d[1] !== 1'b1; n++) rd(2'h2, d);
    rd(2'h3, d);
  endtask
  task automatic get(input logic [7:0] exp);
    logic [15:0] d;
    getb(d);
    chk(d, {8'h00, exp});
  endtask
  // echo off while a unit holds the line low: nothing comes back then
  task automatic send(input logic [7:0] b, input logic echo);
    wait_tx();
    wr(2'h0, {8'h00, b});
    wait_tx();
    if (echo) get(b);
  endtask
  task automatic rreg(input logic [7:0] cmd, input logic [15:0] exp);
    send(8'h55, 1'b1);
    send(cmd, 1'b1);
    get(exp[7:0]);
    get(exp[15:8]);
  endtask
  task automatic wreg(input logic [7:0] cmd, input logic [15:0] v);
    send(8'h55, 1'b1);
    send(cmd, 1'b1);
    send(v[7:0], 1'b1);
    send(v[15:8], 1'b1);
  endtask
  // absence of a reply can only be judged after a fixed span of bit times
  task automatic no_reply();
    repeat (30 * BAUD) @(posedge i_ref_clk);
    rd(2'h2, rv);
    chk(rv & 16'h0002, 16'h0000);
  endtask
  task automatic conv(input logic [15:0] t);
    @(posedge i_ref_clk);
    i_conv_valid <= 1'b1;
    i_conv_temp <= t;
    @(posedge i_ref_clk);
    i_conv_valid <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
  endtask
  task automatic wait_alert();
    for (int n = 0; n < SLOW + 500 && alrt !== 1'b1; n++) @(posedge i_ref_clk);
    repeat (3) @(posedge i_ref_clk);
  endtask
  task automatic watch(input logic [7:0] b);
    logic [9:0] exp;
    exp = {1'b1, b, 1'b0};
    // sampled on the falling edge, clear of the flop that launches the line
    for (int n = 0; n < 500 && link.host_to_dev !== 1'b0; n++) @(negedge i_ref_clk);
    repeat (BAUD / 2) @(negedge i_ref_clk);
    for (int i = 0; i < 10; i++) begin
      chk({15'h0000, link.host_to_dev}, {15'h0000, exp[i]});
      repeat (BAUD) @(negedge i_ref_clk);
    end
  endtask
  task automatic end_sim();
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge i_ref_clk);
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rd(2'h2, rv);
    chk(rv, 16'h0004);
    wr(2'h1, 16'(BAUD));
    fork
      rreg(8'h03, `CSLK_CFG_RST);
      watch(8'h55);
    join
    for (int p = 0; p < 4; p++) rreg({5'h00, p[1:0], 1'b1}, rst_tab[p]);
    send(8'h55, 1'b1);
    send(8'h0B, 1'b1);
    no_reply();
    wreg(8'h04, 16'h0100);
    wreg(8'hF6, 16'h0800);
    rreg(8'h05, 16'h0100);
    rreg(8'h07, 16'h0800);
    for (int k = 0; k < 6; k++) begin
      conv(ct[k]);
      chk(flags, {14'h0008, cf[k]});
    end
    rreg(8'h01, 16'h0100);
    wreg(8'h02, 16'h1200);
    conv(16'h0900);
    conv(16'h0400);
    chk(flags, 16'h0026);
    rreg(8'h03, 16'h5200);
    chk(flags, 16'h0024);
    wreg(8'h02, 16'h0A00);
    chk(flags, 16'h002C);
    conv(16'h0900);
    wait_alert();
    chk(flags, 16'h001E);
    send(8'h55, 1'b0);
    rd(2'h2, rv);
    chk(rv & 16'h0004, 16'h0000);
    send(8'hA9, 1'b0);
    rd(2'h3, rv);
    get(8'h55);
    get(8'hA9);
    chk(flags, 16'h0026);
    repeat (SLOW + 500) @(posedge i_ref_clk);
    chk(flags, 16'h0026);
    wreg(8'h02, 16'h0A00);
    wait_alert();
    chk(flags, 16'h001E);
    send(8'h55, 1'b0);
    send(8'hB4, 1'b0);
    chk(flags, 16'h0020);
    chk({12'h000, uid}, 16'h0000);
    rd(2'h3, rv);
    rreg(8'h07, `CSLK_THIGH_RST);
    rreg(8'h05, `CSLK_TLOW_RST);
    send(8'h55, 1'b1);
    repeat (SLOW + 500) @(posedge i_ref_clk);
    send(8'h03, 1'b1);
    no_reply();
    rreg(8'h03, `CSLK_CFG_RST);
    end_sim();
  end
endmodule
`default_nettype wire
